// [core/hst_pkg.sv]
/*
  Constants for the hot signal throttle control block: pin modes, status
  register layout, reset values and timing counts.
  Assumes a single 20 MHz processor clock.
*/
package hst_pkg;

  // pin modes, one-hot
  typedef enum logic [2:0] {
    HST_MODE_IN   = 3'b001,
    HST_MODE_OUT  = 3'b010,
    HST_MODE_BIDI = 3'b100
  } hst_mode_t;

  // clock timing
  localparam int CLK_NS = 50;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam int FAST_RESP_NS = 1000;
  localparam int FAST_RESP_CYC = FAST_RESP_NS / CLK_NS;
  localparam int EXT_RESP_US = 100;
  localparam int EXT_RESP_CYC = EXT_RESP_US * 1000 / CLK_NS;
  localparam int SELF_STEP_US = 1000;

  // clock modulation, in 1 us ticks
  localparam int MOD_PERIOD_US = 32;
  localparam int TCC_ON_US = 8;
  localparam logic [4:0] MOD_LAST = 5'h1f;
  localparam logic [5:0] TCC_ON = 6'h08;

  // performance levels
  localparam int PERF_W = 4;
  localparam logic [3:0] PERF_MAX = 4'hf;
  localparam logic [3:0] PERF_LOW = 4'h0;
  localparam logic [1:0] DIL_MAX = 2'h3;

  // status register
  localparam logic [11:0] PKG_THERM_STATUS_ADDR = 12'h1b1;
  localparam int ST_TCC = 0;
  localparam int ST_TCC_LOG = 1;
  localparam int ST_HOT = 2;
  localparam int ST_HOT_LOG = 3;
  localparam int ST_CRIT = 4;
  localparam int ST_CRIT_LOG = 5;
  localparam logic [63:0] ST_RESET = 64'h0;

endpackage

// [core/hst_sync2.sv]
/*
  Two flip-flop synchroniser for one level.
  Assumes the input is asynchronous to i_clk_sys.
*/
`timescale 1ns/100ps
module hst_sync2 #(
  parameter logic RST_VAL = 1'b1
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // level in and out
  input wire logic i_async,
  output logic o_sync
);

  logic meta_q;

  // first stage is read only by the second
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= RST_VAL;
      o_sync <= RST_VAL;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule

// [core/hst_clk_mod.sv]
/*
  Clock on/off duty modulator with a 32 us period.
  Assumes a one-cycle 1 us tick from the parent's divider.
*/
`timescale 1ns/100ps
module hst_clk_mod
  import hst_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_tick,
  // duty sources
  input wire logic i_tcc_on,
  input wire logic i_odm_en,
  input wire logic [2:0] i_odm_duty,
  input wire logic [1:0] i_dil_level,
  // result
  output logic o_clk_run,
  output logic o_mod_active
);

  logic [4:0] phase_q;
  logic [5:0] on_len;
  wire logic odm_on;
  wire logic dil_on;

  // factory duty beats the software duty whenever the tcc is engaged
  assign odm_on = i_odm_en && (i_odm_duty != 3'h0);
  assign dil_on = i_dil_level != 2'h0;
  assign on_len = i_tcc_on ? TCC_ON :
                  odm_on ? {1'b0, i_odm_duty, 2'b00} :
                  dil_on ? 6'(6'h20 - {i_dil_level, 3'b000}) : 6'h20;
  assign o_mod_active = i_tcc_on || odm_on || dil_on;

  // phase counter advances once per tick
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      phase_q <= 5'h00;
    end else if (i_tick) begin
      phase_q <= (phase_q == MOD_LAST) ? 5'h00 : 5'(phase_q + 5'h01);
    end
  end

  // run gate is registered to keep glitches off the clock enable
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_clk_run <= 1'b1;
    end else begin
      o_clk_run <= !o_mod_active || ({1'b0, phase_q} < on_len);
    end
  end

endmodule

// [core/hst_ctrl.sv]
/*
  Hot signal throttle control: open-drain hot pin in three modes, fast
  response to external assertion, repeated-assertion demotion, self
  throttling, status register, critical and trip handling.
  Assumes the hot pin and the temperature flags come from outside the
  clock domain and that the status register is reached by its own
  register port at its printed address.
*/
`timescale 1ns/100ps
module hst_ctrl
  import hst_pkg::*;
#(
  parameter int SELF_STEP_TICKS = SELF_STEP_US
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // hot pin, open drain
  input wire logic i_proc_hot_n_in,
  output logic o_proc_hot_n_out,
  output logic o_proc_hot_n_oe,
  // configuration
  input wire logic i_mode_load,
  input wire hst_pkg::hst_mode_t i_mode,
  input wire logic i_int_assert_en,
  input wire logic i_int_deassert_en,
  input wire logic i_therm_int_en,
  input wire logic [15:0] i_demo_window,
  input wire logic [7:0] i_demo_thresh,
  input wire logic i_odm_en,
  input wire logic [2:0] i_odm_duty,
  // temperature and power flags, asynchronous
  input wire logic i_tcc_active,
  input wire logic i_crit_temp,
  input wire logic i_trip_temp,
  input wire logic i_pkg_power_on,
  // status register port
  input wire logic i_reg_rd,
  input wire logic i_reg_wr,
  input wire logic [11:0] i_reg_addr,
  input wire logic [63:0] i_reg_wdata,
  output logic [63:0] o_reg_rdata,
  // throttle results
  output logic [3:0] o_max_perf,
  output logic o_lowest_perf_state,
  output logic o_cap_10khz,
  output logic o_fast_reduce,
  output logic o_clk_run,
  output logic o_hot_int,
  output logic o_therm_int,
  output logic o_shutdown,
  output logic o_thermal_trip_n
);

  hst_mode_t mode_q;
  logic pin_s, tcc_s, crit_s, trip_s, pwr_s;
  logic drive_q, ext_hot_q, crit_q;
  logic [2:0] drv_hist_q;
  logic [4:0] tick_cnt_q;
  logic [15:0] self_cnt_q, win_cnt_q;
  logic [7:0] hits_q;
  logic [3:0] perf_q, demo_cap_q;
  logic [1:0] dil_q;
  logic tcc_log_q, hot_log_q, crit_log_q;
  wire logic tick, self_step, win_end, ext_hot, hot_rise, hot_fall;
  wire logic mode_in, drive_en, sel_st, st_wr, crit_rise, over, mod_act;
  wire logic [3:0] min_cap;
  wire logic [63:0] st_val;

  // all outside levels pass two flops first
  hst_sync2 #(.RST_VAL(1'b1)) u_pin (.i_clk_sys(i_clk_sys),
    .i_rst(i_rst), .i_async(i_proc_hot_n_in), .o_sync(pin_s));
  hst_sync2 #(.RST_VAL(1'b0)) u_tcc (.i_clk_sys(i_clk_sys),
    .i_rst(i_rst), .i_async(i_tcc_active), .o_sync(tcc_s));
  hst_sync2 #(.RST_VAL(1'b0)) u_crit (.i_clk_sys(i_clk_sys),
    .i_rst(i_rst), .i_async(i_crit_temp), .o_sync(crit_s));
  hst_sync2 #(.RST_VAL(1'b0)) u_trip (.i_clk_sys(i_clk_sys),
    .i_rst(i_rst), .i_async(i_trip_temp), .o_sync(trip_s));
  hst_sync2 #(.RST_VAL(1'b0)) u_pwr (.i_clk_sys(i_clk_sys),
    .i_rst(i_rst), .i_async(i_pkg_power_on), .o_sync(pwr_s));

  // mode register, input-only out of reset
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      mode_q <= HST_MODE_IN;
    end else if (i_mode_load) begin
      mode_q <= i_mode;
    end
  end

  // 1 us tick divider
  assign tick = tick_cnt_q == 5'(TICK_CYC - 1);
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      tick_cnt_q <= 5'h00;
    end else begin
      tick_cnt_q <= tick ? 5'h00 : 5'(tick_cnt_q + 5'h01);
    end
  end

  // pin drive: only pull low, and only while the package has power
  assign mode_in = mode_q == HST_MODE_IN;
  assign drive_en = !mode_in && tcc_s && pwr_s;
  assign o_proc_hot_n_out = 1'b0;
  assign o_proc_hot_n_oe = drive_q;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      drive_q <= 1'b0;
      drv_hist_q <= 3'h0;
    end else begin
      drive_q <= drive_en;
      drv_hist_q <= {drv_hist_q[1:0], drive_q};
    end
  end

  // own drive echoes through the synchroniser, so mask it a few cycles
  assign ext_hot = (mode_q != HST_MODE_OUT) && !pin_s
                   && !drive_q && (drv_hist_q == 3'h0);
  assign hot_rise = ext_hot && !ext_hot_q;
  assign hot_fall = !ext_hot && ext_hot_q;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ext_hot_q <= 1'b0;
    end else begin
      ext_hot_q <= ext_hot;
    end
  end

  // external response: straight to lowest, held until release
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_lowest_perf_state <= 1'b0;
      o_cap_10khz <= 1'b0;
      o_fast_reduce <= 1'b0;
      o_hot_int <= 1'b0;
    end else begin
      o_lowest_perf_state <= ext_hot;
      o_cap_10khz <= ext_hot && mode_in;
      o_fast_reduce <= hot_rise && mode_in;
      o_hot_int <= (hot_rise && i_int_assert_en) ||
                   (hot_fall && i_int_deassert_en);
    end
  end

  // self throttling steps one level per long period
  assign self_step = tick && (self_cnt_q == 16'(SELF_STEP_TICKS - 1));
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      self_cnt_q <= 16'h0000;
      perf_q <= PERF_MAX;
    end else begin
      if (tick) begin
        self_cnt_q <= self_step ? 16'h0000 : 16'(self_cnt_q + 16'h0001);
      end
      if (self_step && tcc_s && perf_q != PERF_LOW) begin
        perf_q <= 4'(perf_q - 4'h1);
      end else if (self_step && !tcc_s && perf_q != PERF_MAX) begin
        perf_q <= 4'(perf_q + 4'h1);
      end
    end
  end

  // demotion window: count rising edges, act once per window
  assign win_end = tick && (win_cnt_q >= i_demo_window);
  assign over = hits_q > i_demo_thresh;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      win_cnt_q <= 16'h0000;
      hits_q <= 8'h00;
      demo_cap_q <= PERF_MAX;
      dil_q <= 2'h0;
    end else if (!mode_in) begin
      win_cnt_q <= 16'h0000;
      hits_q <= 8'h00;
      demo_cap_q <= PERF_MAX;
      dil_q <= 2'h0;
    end else begin
      if (tick) begin
        win_cnt_q <= win_end ? 16'h0000 : 16'(win_cnt_q + 16'h0001);
      end
      if (win_end) begin
        hits_q <= 8'(hot_rise);
      end else if (hot_rise && hits_q != 8'hff) begin
        hits_q <= 8'(hits_q + 8'h01);
      end
      if (win_end && over) begin
        if (demo_cap_q != PERF_LOW) begin
          demo_cap_q <= 4'(demo_cap_q - 4'h1);
        end else if (dil_q != DIL_MAX) begin
          dil_q <= 2'(dil_q + 2'h1);
        end
      end else if (win_end) begin
        if (dil_q != 2'h0) begin
          dil_q <= 2'(dil_q - 2'h1);
        end else if (demo_cap_q != PERF_MAX) begin
          demo_cap_q <= 4'(demo_cap_q + 4'h1);
        end
      end
    end
  end

  // frequency ceiling: lowest of all limits
  assign min_cap = (perf_q < demo_cap_q) ? perf_q : demo_cap_q;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_max_perf <= PERF_MAX;
    end else begin
      o_max_perf <= ext_hot ? PERF_LOW : min_cap;
    end
  end

  // duty modulation: tcc only at the floor; external hot adds none
  hst_clk_mod u_mod (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_tick(tick),
    .i_tcc_on(tcc_s && perf_q == PERF_LOW),
    .i_odm_en(i_odm_en),
    .i_odm_duty(i_odm_duty),
    .i_dil_level(dil_q),
    .o_clk_run(o_clk_run),
    .o_mod_active(mod_act)
  );

  // trip is sticky until reset; shutdown is unconditional
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_shutdown <= 1'b0;
      o_thermal_trip_n <= 1'b1;
    end else if (trip_s) begin
      o_shutdown <= 1'b1;
      o_thermal_trip_n <= 1'b0;
    end
  end

  // status register: logs clear by writing zero, a new event wins
  assign sel_st = i_reg_addr == PKG_THERM_STATUS_ADDR;
  assign st_wr = i_reg_wr && sel_st;
  assign crit_rise = tcc_s && crit_s && !crit_q;
  assign st_val = ST_RESET | (64'(tcc_s) << ST_TCC)
                  | (64'(tcc_log_q) << ST_TCC_LOG)
                  | (64'(ext_hot_q) << ST_HOT)
                  | (64'(hot_log_q) << ST_HOT_LOG)
                  | (64'(crit_q) << ST_CRIT)
                  | (64'(crit_log_q) << ST_CRIT_LOG);
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      crit_q <= 1'b0;
      tcc_log_q <= 1'b0;
      hot_log_q <= 1'b0;
      crit_log_q <= 1'b0;
      o_therm_int <= 1'b0;
      o_reg_rdata <= ST_RESET;
    end else begin
      crit_q <= tcc_s && crit_s;
      tcc_log_q <= tcc_s || (tcc_log_q &&
                   !(st_wr && !i_reg_wdata[ST_TCC_LOG]));
      hot_log_q <= ext_hot || (hot_log_q &&
                   !(st_wr && !i_reg_wdata[ST_HOT_LOG]));
      crit_log_q <= (tcc_s && crit_s) || (crit_log_q &&
                    !(st_wr && !i_reg_wdata[ST_CRIT_LOG]));
      o_therm_int <= crit_rise && i_therm_int_en;
      o_reg_rdata <= (i_reg_rd && sel_st) ? st_val : 64'h0;
    end
  end

  // checks
  a_reset_input: assert property (@(posedge i_clk_sys)
    $fell(i_rst) |-> mode_q == HST_MODE_IN && !o_proc_hot_n_oe)
    else $error("mode not input after reset");
  a_fast_resp: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    ($fell(i_proc_hot_n_in) && mode_in && !drive_q && drv_hist_q == 3'h0)
    ##1 (mode_in && !i_proc_hot_n_in && !i_mode_load)[*3]
    |-> ##[0:16] o_cap_10khz)
    else $error("no fast response within 1 us");
  a_demo_off: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !mode_in |=> demo_cap_q == PERF_MAX && dil_q == 2'h0)
    else $error("demotion active outside input mode");
  a_out_ignores: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    mode_q == HST_MODE_OUT |=> !o_lowest_perf_state)
    else $error("output mode reacted to pin");
  a_lowest_hold: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    ext_hot |=> o_lowest_perf_state && o_max_perf == PERF_LOW)
    else $error("lowest state not held");
  a_no_mod_ext: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    ext_hot && !tcc_s && !i_odm_en && dil_q == 2'h0
    |=> o_clk_run)
    else $error("external hot started modulation");
  a_int_edges: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $past(hot_fall) && $past(i_int_deassert_en) |-> o_hot_int)
    else $error("missing de-assertion interrupt");
  a_drive_mask: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    drive_q |=> !o_lowest_perf_state)
    else $error("external sensed while driving");
  a_drive_hot: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    drive_en |=> o_proc_hot_n_oe && !o_proc_hot_n_out)
    else $error("pin not pulled while hot");
  a_trip_out: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    trip_s |=> !o_thermal_trip_n && o_shutdown ##1 !o_thermal_trip_n)
    else $error("trip not asserted");
  a_crit_log: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    tcc_s && crit_s |=> crit_log_q && crit_q)
    else $error("critical log not set");

endmodule

// [verification/hst_platform_model.sv]
/*
  Platform side of the hot pin: a monitor circuit that pulls the shared
  line low on request.
  Assumes a pull-up on the line and an open-drain device driver.
*/
`timescale 1ns/100ps
module hst_platform_model (
  // control from the bench
  input wire logic i_boot_done,
  input wire logic i_req_hot,
  // device driver
  input wire logic i_dev_out,
  input wire logic i_dev_oe,
  // shared line
  output logic o_ext_oe,
  output logic o_pin
);
  // no pull before boot firmware runs, early pulls upset the system
  assign o_ext_oe = i_req_hot & i_boot_done;
  // wired-and with pull-up; nobody ever drives the line high
  assign o_pin = (o_ext_oe | (i_dev_oe & ~i_dev_out)) ? 1'b0 : 1'b1;
endmodule

// [verification/hst_ctrl_tb_top.sv]
/*
  Self-checking bench for the hot signal throttle control block.
  Assumes hst_pkg, hst_ctrl and the platform model are compiled first.
*/
`timescale 1ns/100ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  error_cnt++; $display("BAD %s exp %h got %h", nm, e, g); end end
module hst_ctrl_tb_top;
  import hst_pkg::*;
  localparam int STEP = 4;
  int error_cnt = 0;
  int num_checks = 0;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic boot = 1'b0, req = 1'b0, mload = 1'b0;
  logic ia_en = 1'b0, id_en = 1'b0, ti_en = 1'b0;
  hst_mode_t mode = HST_MODE_IN;
  logic [15:0] win = 16'h0013;
  logic [7:0] thr = 8'h01;
  logic odm = 1'b0;
  logic [2:0] duty = 3'h0;
  logic thermal_control_circuit = 1'b0, crit = 1'b0, trip = 1'b0, pwr = 1'b1;
  logic rd = 1'b0, wr = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [63:0] wd = 64'h0;
  logic [63:0] rdata;
  logic [3:0] max_perf;
  logic pin, ext_oe, hot_out, hot_oe, lowest, cap, fr, crun;
  logic hint, tint, sd, trip_n;
  logic rd_seen = 1'b0;
  logic [63:0] exp_q[$];
  logic saw_fr = 1'b0, saw_hi = 1'b0, saw_ti = 1'b0, saw_stop = 1'b0;
  logic gap_low = 1'b0;

  always #25 clk = ~clk;

  hst_ctrl #(.SELF_STEP_TICKS(STEP)) hst_ctrl_i (
    .i_clk_sys(clk), .i_rst(rst),
    .i_proc_hot_n_in(pin), .o_proc_hot_n_out(hot_out),
    .o_proc_hot_n_oe(hot_oe), .i_mode_load(mload), .i_mode(mode),
    .i_int_assert_en(ia_en), .i_int_deassert_en(id_en),
    .i_therm_int_en(ti_en), .i_demo_window(win), .i_demo_thresh(thr),
    .i_odm_en(odm), .i_odm_duty(duty), .i_tcc_active(thermal_control_circuit),
    .i_crit_temp(crit), .i_trip_temp(trip), .i_pkg_power_on(pwr),
    .i_reg_rd(rd), .i_reg_wr(wr), .i_reg_addr(addr), .i_reg_wdata(wd),
    .o_reg_rdata(rdata), .o_max_perf(max_perf),
    .o_lowest_perf_state(lowest), .o_cap_10khz(cap), .o_fast_reduce(fr),
    .o_clk_run(crun), .o_hot_int(hint), .o_therm_int(tint),
    .o_shutdown(sd), .o_thermal_trip_n(trip_n)
  );

  hst_platform_model hst_platform_model_i (
    .i_boot_done(boot), .i_req_hot(req), .i_dev_out(hot_out),
    .i_dev_oe(hot_oe), .o_ext_oe(ext_oe), .o_pin(pin)
  );

  // read data lands one cycle after the strobe; pulses are latched
  always @(posedge clk) begin : mon
    logic [63:0] e;
    if (rd_seen) begin
      e = exp_q.pop_front();
      `CHK("status", e, rdata)
    end
    rd_seen <= rd;
    if (fr === 1'b1) saw_fr = 1'b1;
    if (hint === 1'b1) saw_hi = 1'b1;
    if (tint === 1'b1) saw_ti = 1'b1;
    if (crun === 1'b0) saw_stop = 1'b1;
  end

  // ends on a falling edge so outputs have settled
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic clr;
    saw_fr = 1'b0;
    saw_hi = 1'b0;
    saw_ti = 1'b0;
    saw_stop = 1'b0;
  endtask

  task automatic reg_read(logic [11:0] a, logic [63:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask

  task automatic reg_write(logic [11:0] a, logic [63:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic set_mode(hst_mode_t m);
    @(posedge clk);
    mode <= m;
    mload <= 1'b1;
    @(posedge clk);
    mload <= 1'b0;
  endtask

  // short pulls with gaps; gap sampled well after the +3 release delay
  task automatic burst(int n);
    repeat (n) begin
      @(posedge clk) req <= 1'b1;
      cyc(10);
      @(posedge clk) req <= 1'b0;
      cyc(30);
      if (max_perf !== PERF_MAX) gap_low = 1'b1;
    end
  endtask

  // on-time of the clock gate over one 32 us modulation period
  task automatic count_on(output int c);
    c = 0;
    repeat (640) begin
      @(negedge clk);
      c += int'(crun);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // a hang is cut short well past the expected 28k cycles
  initial begin
    cyc(80000);
    error_cnt++;
    finish_test;
  end

  initial begin
    int n;
    void'($urandom(86474));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    cyc(2);
    `CHK("oe", 1'b0, hot_oe)
    `CHK("perf", PERF_MAX, max_perf)
    reg_read(PKG_THERM_STATUS_ADDR, ST_RESET);
    // a pull requested before boot must not reach the line
    @(posedge clk) req <= 1'b1;
    cyc(5);
    `CHK("early", 1'b0, ext_oe)
    `CHK("early_low", 1'b0, lowest)
    @(posedge clk);
    req <= 1'b0;
    boot <= 1'b1;
    // input mode: external pull
    @(posedge clk) ia_en <= 1'b1;
    cyc(1);
    clr;
    @(posedge clk) req <= 1'b1;
    cyc(5);
    `CHK("lowest", 1'b1, lowest)
    `CHK("cap", 1'b1, cap)
    `CHK("perf", PERF_LOW, max_perf)
    `CHK("fast", 1'b1, saw_fr)
    `CHK("int_a", 1'b1, saw_hi)
    n = 20 + $urandom_range(0, 200);
    cyc(n);
    `CHK("hold", 1'b1, lowest)
    `CHK("no_mod", 1'b0, saw_stop)
    clr;
    @(posedge clk);
    req <= 1'b0;
    ia_en <= 1'b0;
    id_en <= 1'b1;
    cyc(6);
    `CHK("lowest", 1'b0, lowest)
    `CHK("int_d", 1'b1, saw_hi)
    `CHK("fast", 1'b0, saw_fr)
    reg_read(PKG_THERM_STATUS_ADDR, 64'h8);
    reg_write(PKG_THERM_STATUS_ADDR, 64'h0);
    reg_write(12'h1b0, 64'hffff_ffff_ffff_ffff);
    reg_read(12'h1b0, 64'h0);
    reg_read(PKG_THERM_STATUS_ADDR, 64'h0);
    // output mode: pin ignored, driven on tcc, dropped while unpowered
    set_mode(HST_MODE_OUT);
    @(posedge clk) req <= 1'b1;
    cyc(8);
    `CHK("lowest", 1'b0, lowest)
    @(posedge clk) thermal_control_circuit <= 1'b1;
    cyc(5);
    `CHK("oe", 1'b1, hot_oe)
    `CHK("drv", 1'b0, hot_out)
    @(posedge clk) pwr <= 1'b0;
    cyc(5);
    `CHK("oe", 1'b0, hot_oe)
    @(posedge clk) pwr <= 1'b1;
    cyc(5);
    `CHK("oe", 1'b1, hot_oe)
    // bidirectional: external pull masked while the device drives
    set_mode(HST_MODE_BIDI);
    cyc(8);
    `CHK("lowest", 1'b0, lowest)
    @(posedge clk) thermal_control_circuit <= 1'b0;
    cyc(14);
    `CHK("lowest", 1'b1, lowest)
    `CHK("cap", 1'b0, cap)
    @(posedge clk) req <= 1'b0;
    cyc(2000);
    // demotion stays off in bidirectional mode
    burst(60);
    `CHK("no_demo", 1'b0, gap_low)
    set_mode(HST_MODE_IN);
    cyc(1);
    clr;
    burst(200);
    `CHK("demo", 1'b1, gap_low)
    `CHK("floor", PERF_LOW, max_perf)
    `CHK("dilute", 1'b1, saw_stop)
    cyc(10500);
    `CHK("recover", PERF_MAX, max_perf)
    // software duty, then tcc duty taking over
    @(posedge clk);
    odm <= 1'b1;
    duty <= 3'($urandom_range(1, 7));
    cyc(700);
    count_on(n);
    `CHK("odm_on", int'(duty) * 80, n)
    @(posedge clk) thermal_control_circuit <= 1'b1;
    cyc(2000);
    `CHK("self", PERF_LOW, max_perf)
    count_on(n);
    `CHK("tcc_on", TCC_ON_US * 20, n)
    // critical temperature with tcc engaged
    reg_write(PKG_THERM_STATUS_ADDR, 64'h0);
    @(posedge clk) ti_en <= 1'b1;
    cyc(1);
    clr;
    @(posedge clk) crit <= 1'b1;
    cyc(6);
    `CHK("therm_int", 1'b1, saw_ti)
    reg_read(PKG_THERM_STATUS_ADDR, 64'h33);
    @(posedge clk);
    crit <= 1'b0;
    thermal_control_circuit <= 1'b0;
    odm <= 1'b0;
    cyc(6);
    reg_read(PKG_THERM_STATUS_ADDR, 64'h22);
    reg_write(PKG_THERM_STATUS_ADDR, 64'h0);
    reg_read(PKG_THERM_STATUS_ADDR, 64'h0);
    // catastrophic temperature: sticky trip
    @(posedge clk) trip <= 1'b1;
    cyc(5);
    `CHK("trip_n", 1'b0, trip_n)
    `CHK("shutdown", 1'b1, sd)
    @(posedge clk) trip <= 1'b0;
    cyc(5);
    `CHK("trip_n", 1'b0, trip_n)
    finish_test;
  end
endmodule
